// ==== hdl/otp_pkg.sv ====
// constants, types and helpers for the one-time-programmable configuration loader
// assumes a single 25 MHz clock and a plain synchronous register port
package otp_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int BURN_TIME_US = 320;
    localparam int BURN_CYCLES = BURN_TIME_US * CLK_MHZ;
    localparam int LOCK_TIME_US = 10;
    localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int LINES = 32;
    localparam int DWORDS = 64;
    localparam int SHADOW_WORDS = 128;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [9:0] DATA_BASE = 10'h000;
    localparam logic [9:0] GUARD_OFS = 10'h100;
    localparam logic [9:0] LOCK_OFS = 10'h104;
    localparam logic [9:0] ABW_OFS = 10'h108;
    localparam logic [9:0] STATUS_OFS = 10'h10c;
    localparam logic [9:0] SHADOW_BASE = 10'h200;

    localparam logic [27:0] UNLOCK_CODE = 28'habacada;
    localparam logic [27:0] GUARD_RESET = 28'h0000000;
    localparam int GUARD_PERMIT_BIT = 28;
    localparam int GUARD_BUSY_BIT = 29;
    localparam int ABW_DONE_BIT = 31;
    localparam int ABW_ADDR_LSB = 16;
    localparam int STATUS_DONE_BIT = 0;
    localparam int STATUS_PARSING_BIT = 1;

    // ------------------------------------------------------------
    // structure encodings
    // ------------------------------------------------------------
    localparam logic [2:0] TYPE_END = 3'h0;
    localparam logic [2:0] TYPE_WORD = 3'h1;
    localparam logic [2:0] TYPE_CSR = 3'h2;
    localparam logic [2:0] TYPE_INVALID = 3'h7;
    localparam logic [1:0] RT_POWER = 2'h0;
    localparam logic [1:0] RT_PCIE = 2'h2;
    localparam logic [1:0] RT_ALL = 2'h3;

    typedef enum logic [1:0] {
        CAUSE_POWER = 2'h0,
        CAUSE_PCIE = 2'h1,
        CAUSE_SOFT = 2'h2
    } cause_t;

    typedef enum logic [3:0] {
        PS_START = 4'h1,
        PS_WALK = 4'h2,
        PS_CSR_DATA = 4'h4,
        PS_DONE = 4'h8
    } parse_state_t;

    typedef struct packed {
        logic valid;
        logic csr;
        logic [15:0] addr;
        logic [31:0] data;
    } load_t;

    function automatic logic rt_match(input logic [1:0] rt, input cause_t c);
        case (rt)
            RT_POWER: return c == CAUSE_POWER;
            RT_PCIE: return c != CAUSE_SOFT;
            RT_ALL: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

endpackage

// ==== hdl/otp_program_and_autoload.sv ====
// fuse array, its programming sequencer and the post-reset autoload parser
// assumes reset_cause_i is stable in the cycle after rst_i falls
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ns

// Behaviour
// - array is 32 lines of 64 bits, 2 Kb in total
// - unlock value in the guard code field sets the write permit flag
// - line n lower half is data word 2n, upper half 2n+1
// - each data write burns for 320 us with busy held throughout
// - a line lock takes effect within 10 us and reads back as one
// - all 64 data words read the array directly, no unlock needed
// - a locked line refuses any write, so it cannot be invalidated
// - after every reset the parser loads structures matching the reset kind
// - type 111b entries are skipped, including runs of them
// - type 000b ends parsing and marks the load complete
// - room for 64 word structures or 32 csr structures
// - burns only set fuses; a structure can only be invalidated
// - structures apply in array order so later ones replace earlier
// - bus-write register loads a word as if parsed and sets done on the same edge
// - new fuses take effect at the next reset that matches them
// - reset type 00b power only, 10b pcie, 11b all, 01b never
// - unknown non-zero types are skipped one entry at a time
module otp_program_and_autoload #(
    parameter int BURN_CNT = otp_pkg::BURN_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire otp_pkg::cause_t reset_cause_i,
    input wire logic [9:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output otp_pkg::load_t load_o,
    output logic load_done_o,
    output logic write_permit_o,
    output logic busy_o
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // blank fuses read as zero; the array and its locks survive reset
    logic [31:0] otp_mem [otp_pkg::DWORDS] = '{default: 32'h00000000};
    logic [otp_pkg::LINES-1:0] lock_reg = '0;
    logic [15:0] shadow [otp_pkg::SHADOW_WORDS];

    logic [27:0] guard_code_reg;
    logic [13:0] burn_cnt_reg;
    logic [5:0] burn_idx_reg;
    logic [31:0] burn_val_reg;
    logic [otp_pkg::LINES-1:0] lock_pend_reg;
    logic [7:0] lock_cnt_reg;
    logic [6:0] abw_addr_reg;
    logic [15:0] abw_data_reg;
    logic abw_pend_reg;
    logic abw_done_reg;
    otp_pkg::parse_state_t state_reg;
    otp_pkg::cause_t cause_reg;
    logic [6:0] idx_reg;
    logic [31:0] csr_hdr_reg;
    otp_pkg::load_t emit_next;
    logic [31:0] ent;
    logic burn_ok;
    logic lock_ok;

    function automatic logic is_data(input logic [9:0] a);
        return a < otp_pkg::GUARD_OFS;
    endfunction

    function automatic logic is_shadow(input logic [9:0] a);
        return a >= otp_pkg::SHADOW_BASE;
    endfunction

    // ------------------------------------------------------------
    // programming sequencer
    // ------------------------------------------------------------
    // line n is word index {n,half}: address bits [7:3] pick the line
    assign burn_ok = reg_wr_i && is_data(reg_addr_i) && write_permit_o && !busy_o
        && !lock_reg[reg_addr_i[7:3]];
    assign lock_ok = reg_wr_i && reg_addr_i == otp_pkg::LOCK_OFS && write_permit_o;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            guard_code_reg <= otp_pkg::GUARD_RESET;
            write_permit_o <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == otp_pkg::GUARD_OFS) begin
            guard_code_reg <= reg_wdata_i[27:0];
            write_permit_o <= reg_wdata_i[27:0] == otp_pkg::UNLOCK_CODE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            burn_cnt_reg <= '0;
            burn_idx_reg <= '0;
            burn_val_reg <= '0;
            busy_o <= 1'b0;
        end else if (burn_ok) begin
            burn_cnt_reg <= 14'(BURN_CNT);
            burn_idx_reg <= reg_addr_i[7:2];
            burn_val_reg <= reg_wdata_i;
            busy_o <= 1'b1;
        end else if (burn_cnt_reg != '0) begin
            burn_cnt_reg <= burn_cnt_reg - 14'h0001;
            busy_o <= burn_cnt_reg != 14'h0001;
        end
    end

    // fuses only go from blank to blown, so a burn can never clear a bit
    always_ff @(posedge ref_clk_i) begin
        if (busy_o && burn_cnt_reg == 14'h0001) begin
            otp_mem[burn_idx_reg] <= otp_mem[burn_idx_reg] | burn_val_reg;
        end
    end

    // a new lock request restarts the settle time for the whole batch
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            lock_pend_reg <= '0;
            lock_cnt_reg <= '0;
        end else if (lock_ok) begin
            lock_pend_reg <= lock_pend_reg | (reg_wdata_i & ~lock_reg);
            lock_cnt_reg <= 8'(otp_pkg::LOCK_CYCLES);
        end else if (lock_cnt_reg != '0) begin
            lock_cnt_reg <= lock_cnt_reg - 8'h01;
            if (lock_cnt_reg == 8'h01) begin
                lock_pend_reg <= '0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_i && !lock_ok && lock_cnt_reg == 8'h01) begin
            lock_reg <= lock_reg | lock_pend_reg;
        end
    end

    // ------------------------------------------------------------
    // autoload bus write
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            abw_addr_reg <= '0;
            abw_data_reg <= '0;
            abw_pend_reg <= 1'b0;
            abw_done_reg <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == otp_pkg::ABW_OFS) begin
            abw_addr_reg <= reg_wdata_i[otp_pkg::ABW_ADDR_LSB +: 7];
            abw_data_reg <= reg_wdata_i[15:0];
            abw_pend_reg <= 1'b1;
            abw_done_reg <= 1'b0;
        end else if (abw_pend_reg && state_reg == otp_pkg::PS_DONE) begin
            abw_pend_reg <= 1'b0;
            abw_done_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // autoload parser
    // ------------------------------------------------------------
    assign ent = otp_mem[idx_reg[5:0]];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= otp_pkg::PS_START;
            cause_reg <= otp_pkg::CAUSE_POWER;
            idx_reg <= '0;
            csr_hdr_reg <= '0;
            load_done_o <= 1'b0;
        end else begin
            case (state_reg)
                otp_pkg::PS_START: begin
                    // the fuses as they stand now are what this reset sees
                    cause_reg <= reset_cause_i;
                    idx_reg <= '0;
                    state_reg <= otp_pkg::PS_WALK;
                end
                otp_pkg::PS_WALK: begin
                    if (idx_reg[6] || ent[2:0] == otp_pkg::TYPE_END) begin
                        state_reg <= otp_pkg::PS_DONE;
                        load_done_o <= 1'b1;
                    end else begin
                        // invalidated and unknown entries fall through to the next dword
                        idx_reg <= idx_reg + 7'h01;
                        if (ent[2:0] == otp_pkg::TYPE_CSR) begin
                            csr_hdr_reg <= ent;
                            state_reg <= otp_pkg::PS_CSR_DATA;
                        end
                    end
                end
                otp_pkg::PS_CSR_DATA: begin
                    if (idx_reg[6]) begin
                        state_reg <= otp_pkg::PS_DONE;
                        load_done_o <= 1'b1;
                    end else begin
                        idx_reg <= idx_reg + 7'h01;
                        state_reg <= otp_pkg::PS_WALK;
                    end
                end
                default: begin
                    state_reg <= otp_pkg::PS_DONE;
                end
            endcase
        end
    end

    always_comb begin
        emit_next = '0;
        case (state_reg)
            otp_pkg::PS_WALK: begin
                if (!idx_reg[6] && ent[2:0] == otp_pkg::TYPE_WORD
                    && otp_pkg::rt_match(ent[4:3], cause_reg)) begin
                    emit_next = {1'b1, 1'b0, 9'h000, ent[15:9], 16'h0000, ent[31:16]};
                end
            end
            otp_pkg::PS_CSR_DATA: begin
                if (!idx_reg[6] && otp_pkg::rt_match(csr_hdr_reg[4:3], cause_reg)) begin
                    emit_next = {1'b1, 1'b1, csr_hdr_reg[31:16], ent};
                end
            end
            otp_pkg::PS_DONE: begin
                if (abw_pend_reg) begin
                    emit_next = {1'b1, 1'b0, 9'h000, abw_addr_reg, 16'h0000, abw_data_reg};
                end
            end
            default: begin
                emit_next = '0;
            end
        endcase
    end

    // later loads overwrite earlier ones in the word shadow
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            load_o <= '0;
            for (int i = 0; i < otp_pkg::SHADOW_WORDS; i++) begin
                shadow[i] <= 16'h0000;
            end
        end else begin
            load_o <= emit_next;
            if (emit_next.valid && !emit_next.csr) begin
                shadow[emit_next.addr[6:0]] <= emit_next.data[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= '0;
        end else if (is_data(reg_addr_i)) begin
            reg_rdata_o <= otp_mem[reg_addr_i[7:2]];
        end else if (reg_addr_i == otp_pkg::GUARD_OFS) begin
            reg_rdata_o <= {2'h0, busy_o, write_permit_o, guard_code_reg};
        end else if (reg_addr_i == otp_pkg::LOCK_OFS) begin
            reg_rdata_o <= lock_reg;
        end else if (reg_addr_i == otp_pkg::ABW_OFS) begin
            reg_rdata_o <= {abw_done_reg, 8'h00, abw_addr_reg, abw_data_reg};
        end else if (reg_addr_i == otp_pkg::STATUS_OFS) begin
            reg_rdata_o <= {30'h00000000, state_reg != otp_pkg::PS_DONE, load_done_o};
        end else if (is_shadow(reg_addr_i)) begin
            reg_rdata_o <= {16'h0000, shadow[reg_addr_i[8:2]]};
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_UNLOCK_PERMIT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == otp_pkg::GUARD_OFS && reg_wdata_i[27:0] == otp_pkg::UNLOCK_CODE
        |=> write_permit_o)
        else $error("unlock code did not raise the write permit");
    AST_BURN_BUSY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        burn_ok |=> busy_o [*8])
        else $error("busy dropped early in a burn");
    AST_BURN_LENGTH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        busy_o && burn_cnt_reg == 14'h0001 |=> !busy_o && burn_cnt_reg == 14'h0000)
        else $error("burn did not end when its count ran out");
    AST_LOCKED_REFUSE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && is_data(reg_addr_i) && lock_reg[reg_addr_i[7:3]] && !busy_o |=> !busy_o)
        else $error("a locked line started a burn");
    AST_GUARD_REFUSE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && is_data(reg_addr_i) && !write_permit_o && !busy_o |=> !busy_o)
        else $error("burn started without the unlock code");
    AST_BUSY_IGNORE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && is_data(reg_addr_i) && busy_o && burn_cnt_reg != 14'h0001
        |=> $stable(burn_idx_reg) && $stable(burn_val_reg))
        else $error("a burn request during busy was taken");
    AST_STOP_ON_END: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg == otp_pkg::PS_WALK && !idx_reg[6] && ent[2:0] == otp_pkg::TYPE_END
        |=> state_reg == otp_pkg::PS_DONE && load_done_o)
        else $error("parser went on past an end entry");
    AST_SKIP_INVALID: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_reg == otp_pkg::PS_WALK && !idx_reg[6] && ent[2:0] == otp_pkg::TYPE_INVALID
        |=> idx_reg == $past(idx_reg) + 7'h01 && !load_o.valid && state_reg == otp_pkg::PS_WALK)
        else $error("invalidated entry was not skipped");
    AST_ABW_DONE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == otp_pkg::ABW_OFS |-> ##[1:200] abw_done_reg)
        else $error("bus write never completed");
    AST_LOCK_TIME: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        lock_ok && reg_wdata_i[0] ##1 !lock_ok [*8] |-> ##[1:250] lock_reg[0])
        else $error("line lock did not take effect in time");

endmodule

// ==== bench/test_otp_program_and_autoload.sv ====
// self-checking bench for the fuse array loader: burns, locks, parse after reset, bus write
// assumes the loader is built with a short burn count; everything is reached through its ports
`timescale 1ns/1ns

`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch %s expected %0h seen %0h", nm, (exp), (got)); end end

module test_otp_program_and_autoload;
    localparam int BURN = 20;
    localparam int LIMIT = 20000;
    logic ref_clk_i;
    logic rst_i = 1'b1;
    otp_pkg::cause_t reset_cause_i = otp_pkg::CAUSE_POWER;
    logic [9:0] reg_addr_i = 10'h000;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    otp_pkg::load_t load_o;
    logic load_done_o;
    logic write_permit_o;
    logic busy_o;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    logic [31:0] img [64];
    otp_pkg::load_t got_q [$];
    otp_pkg::load_t exp_q [$];

    otp_program_and_autoload #(.BURN_CNT(BURN)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .reset_cause_i(reset_cause_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .load_o(load_o),
        .load_done_o(load_done_o), .write_permit_o(write_permit_o), .busy_o(busy_o));

    // ------------------------------------------------------------
    // clock, watchdog and load monitor
    // ------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            results();
        end
    end

    always @(posedge ref_clk_i) begin
        if (load_o.valid === 1'b1) begin
            got_q.push_back(load_o);
        end
    end

    // ------------------------------------------------------------
    // bus tasks and expectations
    // ------------------------------------------------------------
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    task automatic burn(input int i, input logic [31:0] v);
        int n;
        n = 0;
        wr(10'(i * 4), v);
        #1;
        `CHK("busy", 1'b1, busy_o)
        while (busy_o === 1'b1 && n < 1000) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        `CHK("burn cycles", BURN, n)
        img[i] = img[i] | v;
    endtask

    // reset is held 12 cycles; the cause must already stand when it is released
    task automatic do_reset(input otp_pkg::cause_t c);
        int n;
        logic [31:0] s;
        n = 0;
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        reset_cause_i <= c;
        repeat (11) @(posedge ref_clk_i);
        #1;
        `CHK("outputs in reset", 3'h0, {load_done_o, write_permit_o, busy_o})
        got_q.delete();
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        while (load_done_o !== 1'b1 && n < 300) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        `CHK("load done", 1'b1, load_done_o)
        rd(otp_pkg::STATUS_OFS, s);
        `CHK("status", 32'h00000001, s)
        repeat (2) @(posedge ref_clk_i);
    endtask

    function automatic logic hit(input logic [1:0] rt, input otp_pkg::cause_t c);
        return rt == 2'h3 || (rt == 2'h2 && c != otp_pkg::CAUSE_SOFT) || (rt == 2'h0 && c == otp_pkg::CAUSE_POWER);
    endfunction

    function automatic logic [31:0] mkw(input logic [6:0] a, input logic [1:0] rt, input logic [15:0] d);
        return {d, a, 4'h0, rt, 3'h1};
    endfunction

    task automatic check_loads(input otp_pkg::cause_t c);
        int i;
        otp_pkg::load_t e;
        logic [31:0] m;
        i = 0;
        exp_q.delete();
        while (i < 64 && img[i][2:0] != 3'h0) begin
            e = '0;
            e.valid = 1'b1;
            if (img[i][2:0] == 3'h1 && hit(img[i][4:3], c)) begin
                e.addr = {9'h0, img[i][15:9]};
                e.data = {16'h0, img[i][31:16]};
                exp_q.push_back(e);
            end
            if (img[i][2:0] == 3'h2) begin
                if (hit(img[i][4:3], c) && i < 63) begin
                    e.csr = 1'b1;
                    e.addr = img[i][31:16];
                    e.data = img[i + 1];
                    exp_q.push_back(e);
                end
                i++;
            end
            i++;
        end
        `CHK("load count", exp_q.size(), got_q.size())
        foreach (exp_q[k]) begin
            if (k < got_q.size()) begin
                m = exp_q[k].csr ? 32'hffffffff : 32'h0000ffff;
                `CHK("load csr", exp_q[k].csr, got_q[k].csr)
                `CHK("load addr", exp_q[k].addr, got_q[k].addr)
                `CHK("load data", exp_q[k].data, got_q[k].data & m)
            end
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [31:0] plan [15];
        logic [15:0] bw;
        int n;
        otp_pkg::cause_t causes [3];
        n = $urandom(39533);
        causes = '{otp_pkg::CAUSE_POWER, otp_pkg::CAUSE_PCIE, otp_pkg::CAUSE_SOFT};
        img = '{default: 32'h0};
        do_reset(otp_pkg::CAUSE_POWER);
        `CHK("blank loads", 0, got_q.size())
        wr(10'h000, 32'hffffffff);
        wr(otp_pkg::LOCK_OFS, 32'h2);
        #1;
        `CHK("busy locked out", 1'b0, busy_o)
        repeat (260) @(posedge ref_clk_i);
        rd(10'h000, d);
        `CHK("word without permit", 32'h0, d)
        rd(otp_pkg::LOCK_OFS, d);
        `CHK("lock without permit", 1'b0, d[1])
        rd(10'h180, d);
        `CHK("unmapped read", 32'h0, d)
        wr(otp_pkg::GUARD_OFS, {4'h0, otp_pkg::UNLOCK_CODE});
        #1;
        `CHK("permit", 1'b1, write_permit_o)
        rd(otp_pkg::GUARD_OFS, d);
        `CHK("guard read", {1'b0, 1'b1, otp_pkg::UNLOCK_CODE}, d[29:0])
        @(posedge ref_clk_i);
        #1;
        `CHK("read data after its cycle", 32'h0, reg_rdata_o)
        // no traffic and no flash in this bench, so burning starts right away
        // image: repeats, invalid runs, unknown types, every reset kind, a stop, an entry past it
        plan = '{default: 32'h0};
        plan[0] = mkw(7'h0a, 2'h3, 16'($urandom()));
        plan[1] = {29'($urandom()), 3'h7};
        plan[2] = {29'($urandom()), 3'h7};
        plan[3] = {29'($urandom()), 3'h3};
        plan[4] = mkw(7'h0a, 2'h3, 16'($urandom()));
        plan[5] = mkw(7'h1c, 2'h0, 16'($urandom()));
        plan[6] = mkw(7'h22, 2'h2, 16'($urandom()));
        plan[7] = {16'($urandom()), 11'h0, 2'h3, 3'h2};
        plan[8] = $urandom();
        plan[9] = {29'($urandom()), 3'h4};
        plan[10] = mkw(7'h2e, 2'h1, 16'($urandom()));
        plan[11] = {16'($urandom()), 11'h0, 2'h2, 3'h2};
        plan[12] = $urandom();
        plan[14] = mkw(7'h05, 2'h3, 16'($urandom()));
        for (int k = 0; k < 15; k++) begin
            if (plan[k] != 32'h0) begin
                burn(k, plan[k]);
            end
        end
        wr(10'h050, 32'h0000a5a5);
        wr(10'h054, 32'hffffffff);
        img[20] = 32'h0000a5a5;
        n = 0;
        while (busy_o === 1'b1 && n < 100) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        wr(otp_pkg::LOCK_OFS, 32'h1);
        repeat (251) @(posedge ref_clk_i);
        rd(otp_pkg::LOCK_OFS, d);
        `CHK("line lock", 1'b1, d[0])
        wr(10'h000, 32'h7);
        #1;
        `CHK("busy on locked line", 1'b0, busy_o)
        burn(6, 32'h7);
        for (int k = 0; k < 64; k++) begin
            rd(10'(k * 4), d);
            `CHK("array word", img[k], d)
        end
        wr(otp_pkg::GUARD_OFS, 32'h0);
        #1;
        `CHK("permit cleared", 1'b0, write_permit_o)
        wr(10'h078, 32'h1);
        #1;
        `CHK("busy after clear", 1'b0, busy_o)
        foreach (causes[k]) begin
            do_reset(causes[k]);
            check_loads(causes[k]);
            rd(otp_pkg::SHADOW_BASE + 10'h028, d);
            `CHK("shadow repeat", plan[4][31:16], d[15:0])
        end
        bw = 16'($urandom());
        got_q.delete();
        wr(otp_pkg::ABW_OFS, {9'h0, 7'h33, bw});
        n = 0;
        d = 32'h0;
        while (d[31] !== 1'b1 && n < 20) begin
            rd(otp_pkg::ABW_OFS, d);
            n++;
        end
        `CHK("bus write done", 1'b1, d[31])
        `CHK("bus write loads", 1, got_q.size())
        if (got_q.size() > 0) begin
            `CHK("bus write item", {17'h00033, bw}, {got_q[0].csr, got_q[0].addr, got_q[0].data[15:0]})
        end
        rd(otp_pkg::SHADOW_BASE + 10'h0cc, d);
        `CHK("bus write shadow", bw, d[15:0])
        results();
    end
endmodule
